// >>> core/uis_irq_shadow.v
/*
 * UART interrupt generation, prioritisation and identification, with the
 * programmable transmit-empty threshold mode and the shadow register
 * aliases. Registers sit on an APB slave in the mclk domain.
 * Assumes the serial datapath (FIFOs, framing, baud) is outside: it reports
 * FIFO levels, push/pop strobes, error strobes and a baud tick, and takes
 * the one-cycle read/write strobes that this block produces.
 */
`default_nettype none

`include "uis_consts.vh"

// Behaviour
// - Interrupt output high while any enabled source is active.
// - Identification low nibble gives top pending code; 0001 when none.
// - Line errors give code 0110 first; line status read clears it.
// - Data available gives 0100; trigger level in FIFO mode, else one char.
// - FIFO mode timeout gives 1100 after four idle character times.
// - Transmit empty gives 0010; threshold compare in threshold mode.
// - Transmit empty cleared by identification read returning 0010, holding write, or refill in threshold mode.
// - Threshold from FIFO control bits 5..4: empty, two, quarter, half.
// - In threshold mode line status bit 5 shows transmit FIFO full.
// - FIFOs disabled forces threshold mode off.
// - Otherwise interrupt and status bit 5 show holding register empty.
// - Shadow receive range reads all return the receive buffer.
// - Shadow transmit range writes all go to the holding register.
// - Shadow FIFO enable touches only FIFO control bit 0.
// - Shadow receive trigger touches only FIFO control bits 7..6.
// - Shadow transmit trigger touches only FIFO control bits 5..4.
module uis_irq_shadow (
	input  wire        mclk,          // Block clock, 100 MHz
	input  wire        rst_n,         // Synchronous reset, active low
	input  wire        psel,          // APB select
	input  wire        penable,       // APB access phase
	input  wire        pwrite,        // APB direction, high for write
	input  wire [11:0] paddr,         // APB byte address
	input  wire [31:0] pwdata,        // APB write data
	output reg  [31:0] prdata,        // APB read data
	output reg         pready,        // APB ready
	output reg         pslverr,       // APB error, unmapped address
	input  wire [7:0]  rx_data,       // Receive buffer head character
	input  wire [4:0]  rx_level,      // Receive FIFO fill, 0..16
	input  wire [4:0]  tx_level,      // Transmit FIFO fill, 0..16
	input  wire        rx_push,       // Character entered receive FIFO
	input  wire        rx_pop,        // Character left receive FIFO
	input  wire        rx_overrun,    // Overrun strobe
	input  wire        rx_parity_err, // Parity error strobe
	input  wire        rx_frame_err,  // Framing error strobe
	input  wire        rx_break,      // Break detected strobe
	input  wire        tx_idle,       // Transmit shifter idle
	input  wire        baud_tick,     // One baud clock (1/16 bit)
	input  wire [3:0]  char_bits,     // Bits per character incl. start/stop
	output reg         rx_read_stb,   // Pop receive buffer
	output reg         tx_write_stb,  // Push transmit holding register
	output reg  [7:0]  tx_data,       // Character for transmit holding
	output reg  [7:0]  fifo_control_q,// FIFO control for the datapath
	output reg         irq            // Interrupt, active high level
);

	// ****************************************************************
	// Address decode
	// ****************************************************************
	reg  [7:0]  irq_enable_reg_q;
	reg         rls_q;
	reg         tx_holding_empty_q;
	reg         cto_q;
	reg  [11:0] cto_cnt_q;
	reg  [`UIS_EVT_W-1:0] evt_stat_q;
	reg  [`UIS_EVT_W-1:0] evt_en_q;
	reg         tx_holding_empty_cond_q;

	function is_srbr;
		input [11:0] a;
		begin
			is_srbr = (a >= `UIS_OFS_SRBR_LO) && (a <= `UIS_OFS_SRBR_HI) && (a[1:0] == 2'b00);
		end
	endfunction

	function mapped;
		input [11:0] a;
		begin
			if (a == `UIS_OFS_RBR_THR)
				mapped = 1'b1;
			else if (a == `UIS_OFS_IER || a == `UIS_OFS_IIR_FCR || a == `UIS_OFS_LSR)
				mapped = 1'b1;
			else if (is_srbr(a))
				mapped = 1'b1;
			else if (a == `UIS_OFS_SFE || a == `UIS_OFS_SRT || a == `UIS_OFS_STET)
				mapped = 1'b1;
			else if (a == `UIS_OFS_EVT_STAT || a == `UIS_OFS_EVT_CLR)
				mapped = 1'b1;
			else if (a == `UIS_OFS_EVT_EN || a == `UIS_OFS_TX_LEVEL)
				mapped = 1'b1;
			else
				mapped = 1'b0;
		end
	endfunction

	// Access completes one cycle into the access phase: pready registered once
	wire acc    = psel && penable && !pready;
	wire ok     = acc && mapped(paddr);
	wire wr     = ok && pwrite;
	wire rd     = ok && !pwrite;
	wire rx_hit = (paddr == `UIS_OFS_RBR_THR) || is_srbr(paddr);
	wire rbr_rd = rd && rx_hit;
	wire thr_wr = wr && rx_hit;
	wire iir_rd = rd && (paddr == `UIS_OFS_IIR_FCR);
	wire lsr_rd = rd && (paddr == `UIS_OFS_LSR);

	// ****************************************************************
	// Mode and threshold
	// ****************************************************************
	wire       fifo_on  = fifo_control_q[`UIS_FCR_FIFO_EN];
	wire       pmode    = irq_enable_reg_q[`UIS_IER_PTHRE] && fifo_on;
	wire [1:0] tet      = fifo_control_q[`UIS_FCR_TET_HI:`UIS_FCR_TET_LO];
	reg  [4:0] tx_thr;
	reg  [4:0] rx_trig;

	always @* begin
		case (tet)
		`UIS_TET_TWO:     tx_thr = `UIS_LVL_TWO;
		`UIS_TET_QUARTER: tx_thr = `UIS_LVL_QUARTER;
		`UIS_TET_HALF:    tx_thr = `UIS_LVL_HALF;
		default:          tx_thr = 5'h00;
		endcase
		case (fifo_control_q[`UIS_FCR_RT_HI:`UIS_FCR_RT_LO])
		2'h1:    rx_trig = `UIS_RT_QUARTER;
		2'h2:    rx_trig = `UIS_RT_HALF;
		2'h3:    rx_trig = `UIS_RT_FULL2;
		default: rx_trig = `UIS_RT_ONE;
		endcase
	end

	wire tx_full  = (tx_level == `UIS_FIFO_DEPTH);
	wire tx_empty = (tx_level == 5'h00);
	// Threshold mode compares level; normal mode wants fully empty
	wire tx_holding_empty_cond = pmode ? (tx_level <= tx_thr) : tx_empty;
	wire lsr_b5    = pmode ? tx_full : tx_empty;

	// ****************************************************************
	// Interrupt sources
	// ****************************************************************
	wire err_evt  = rx_overrun || rx_parity_err || rx_frame_err || rx_break;
	wire rda_act  = fifo_on ? (rx_level >= rx_trig) : (rx_level != 5'h00);
	wire rls_en   = irq_enable_reg_q[`UIS_IER_RLS] && rls_q;
	wire rda_en   = irq_enable_reg_q[`UIS_IER_RDA] && rda_act;
	wire cto_en   = irq_enable_reg_q[`UIS_IER_RDA] && cto_q;
	wire tx_holding_empty_en  = irq_enable_reg_q[`UIS_IER_TX_HOLDING_EMPTY] && tx_holding_empty_q;
	// Four character times of sixteen ticks a bit: char_bits times 64
	wire [11:0] cto_lim = {2'b00, char_bits, 6'h00};

	reg [3:0] id_d;
	always @* begin
		if (rls_en)
			id_d = `UIS_ID_RLS;
		else if (rda_en)
			id_d = `UIS_ID_RDA;
		else if (cto_en)
			id_d = `UIS_ID_CTO;
		else if (tx_holding_empty_en)
			id_d = `UIS_ID_TX_HOLDING_EMPTY;
		else
			id_d = `UIS_ID_NONE;
	end

	wire [`UIS_EVT_W-1:0] evt_now = {rls_en | rda_en | cto_en | tx_holding_empty_en,
	                                 tx_holding_empty_en, cto_en, rda_en, rls_en};
	wire evt_clr_wr = wr && (paddr == `UIS_OFS_EVT_CLR);

	// ****************************************************************
	// Sticky event status
	// ****************************************************************
	genvar g;
	generate
		for (g = 0; g < `UIS_EVT_W; g = g + 1) begin : g_evt
			always @(posedge mclk) begin
				if (!rst_n)
					evt_stat_q[g] <= 1'b0;
				else if (evt_now[g])
					evt_stat_q[g] <= 1'b1;          // Set wins over clear
				else if (evt_clr_wr && pwdata[g])
					evt_stat_q[g] <= 1'b0;
			end
		end
	endgenerate

	// ****************************************************************
	// Source state
	// ****************************************************************
	always @(posedge mclk) begin
		if (!rst_n) begin
			rls_q     <= 1'b0;
			tx_holding_empty_q    <= 1'b0;
			cto_q     <= 1'b0;
			cto_cnt_q <= 12'h000;
			tx_holding_empty_cond_q <= 1'b0;
		end else begin
			tx_holding_empty_cond_q <= tx_holding_empty_cond;
			// New error in the read cycle wins over the clear
			if (err_evt)
				rls_q <= 1'b1;
			else if (lsr_rd)
				rls_q <= 1'b0;
			// Transmit empty: rising condition sets, listed events clear
			if (thr_wr || (pmode && !tx_holding_empty_cond))
				tx_holding_empty_q <= 1'b0;
			else if (iir_rd && id_d == `UIS_ID_TX_HOLDING_EMPTY)
				tx_holding_empty_q <= 1'b0;
			// Edge set: a cleared indication stays clear until the condition returns
			else if (tx_holding_empty_cond && !tx_holding_empty_cond_q)
				tx_holding_empty_q <= 1'b1;
			if (!fifo_on || rx_level == 5'h00 || rx_push || rx_pop) begin
				cto_cnt_q <= 12'h000;
				if (!fifo_on || rx_level == 5'h00 || rbr_rd || rx_pop)
					cto_q <= 1'b0;
			end else if (rbr_rd) begin
				cto_q <= 1'b0;
			end else if (baud_tick) begin
				if (cto_cnt_q >= cto_lim - 12'h001)
					cto_q <= 1'b1;
				else
					cto_cnt_q <= cto_cnt_q + 12'h001;
			end
		end
	end

	// ****************************************************************
	// Registers and APB
	// ****************************************************************
	always @(posedge mclk) begin
		if (!rst_n) begin
			irq_enable_reg_q <= `UIS_RST_IER;
			fifo_control_q   <= `UIS_RST_FCR;
			evt_en_q         <= `UIS_RST_EVT_EN;
			prdata           <= 32'h0000_0000;
			pready           <= 1'b0;
			pslverr          <= 1'b0;
			rx_read_stb      <= 1'b0;
			tx_write_stb     <= 1'b0;
			tx_data          <= 8'h00;
			irq              <= 1'b0;
		end else begin
			pready       <= acc;
			pslverr      <= acc && !mapped(paddr);
			rx_read_stb  <= rbr_rd;
			tx_write_stb <= thr_wr;
			if (thr_wr)
				tx_data <= pwdata[7:0];
			irq <= (id_d != `UIS_ID_NONE) ||
			       |(evt_stat_q & evt_en_q);
			if (wr) begin
				if (paddr == `UIS_OFS_IER)
					irq_enable_reg_q <= pwdata[7:0];
				else if (paddr == `UIS_OFS_IIR_FCR)
					fifo_control_q <= pwdata[7:0];
				else if (paddr == `UIS_OFS_SFE)
					fifo_control_q[`UIS_FCR_FIFO_EN] <= pwdata[0];
				else if (paddr == `UIS_OFS_SRT)
					fifo_control_q[`UIS_FCR_RT_HI:`UIS_FCR_RT_LO] <= pwdata[1:0];
				else if (paddr == `UIS_OFS_STET)
					fifo_control_q[`UIS_FCR_TET_HI:`UIS_FCR_TET_LO] <= pwdata[1:0];
				else if (paddr == `UIS_OFS_EVT_EN)
					evt_en_q <= pwdata[`UIS_EVT_W-1:0];
			end
			prdata <= 32'h0000_0000;
			if (rd) begin
				if (rx_hit)
					prdata <= {24'h000000, rx_data};
				else if (paddr == `UIS_OFS_IER)
					prdata <= {24'h000000, irq_enable_reg_q};
				else if (paddr == `UIS_OFS_IIR_FCR)
					prdata <= {24'h000000, fifo_on, fifo_on, 2'b00, id_d};
				else if (paddr == `UIS_OFS_LSR)
					prdata <= {24'h000000, 1'b0, tx_empty && tx_idle, lsr_b5,
					           rls_q, 3'b000, rx_level != 5'h00};
				else if (paddr == `UIS_OFS_SFE)
					prdata <= {31'h00000000, fifo_on};
				else if (paddr == `UIS_OFS_SRT)
					prdata <= {30'h00000000, fifo_control_q[`UIS_FCR_RT_HI:`UIS_FCR_RT_LO]};
				else if (paddr == `UIS_OFS_STET)
					prdata <= {30'h00000000, tet};
				else if (paddr == `UIS_OFS_EVT_STAT)
					prdata <= {27'h0000000, evt_stat_q};
				else if (paddr == `UIS_OFS_EVT_EN)
					prdata <= {27'h0000000, evt_en_q};
				else if (paddr == `UIS_OFS_TX_LEVEL)
					prdata <= {27'h0000000, tx_level};
			end
		end
	end

endmodule

`default_nettype wire

// >>> core/uis_consts.vh
/*
 * Constants for the UART interrupt and shadow register block: register
 * offsets, field positions, interrupt codes, reset values and timing.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef UIS_CONSTS_VH
`define UIS_CONSTS_VH

// Register byte offsets (one 32-bit word each)
`define UIS_OFS_RBR_THR      12'h000
`define UIS_OFS_IER          12'h004
`define UIS_OFS_IIR_FCR      12'h008
`define UIS_OFS_LSR          12'h014
`define UIS_OFS_SRBR_LO      12'h030
`define UIS_OFS_SRBR_HI      12'h06C
`define UIS_OFS_SFE          12'h098
`define UIS_OFS_SRT          12'h09C
`define UIS_OFS_STET         12'h0A0
`define UIS_OFS_EVT_STAT     12'h0C0
`define UIS_OFS_EVT_CLR      12'h0C4
`define UIS_OFS_EVT_EN       12'h0C8
`define UIS_OFS_TX_LEVEL     12'h0CC

// Enable register fields
`define UIS_IER_RDA          0
`define UIS_IER_TX_HOLDING_EMPTY         1
`define UIS_IER_RLS          2
`define UIS_IER_PTHRE        7

// FIFO control fields
`define UIS_FCR_FIFO_EN      0
`define UIS_FCR_TET_LO       4
`define UIS_FCR_TET_HI       5
`define UIS_FCR_RT_LO        6
`define UIS_FCR_RT_HI        7

// Line status fields
`define UIS_LSR_DR           0
`define UIS_LSR_OE           1
`define UIS_LSR_PE           2
`define UIS_LSR_FE           3
`define UIS_LSR_BI           4
`define UIS_LSR_TX_HOLDING_EMPTY         5
`define UIS_LSR_TEMT         6

// Interrupt identification codes
`define UIS_ID_NONE          4'h1
`define UIS_ID_RLS           4'h6
`define UIS_ID_RDA           4'h4
`define UIS_ID_CTO           4'hC
`define UIS_ID_TX_HOLDING_EMPTY          4'h2

// Transmit threshold codes and levels
`define UIS_TET_EMPTY        2'h0
`define UIS_TET_TWO          2'h1
`define UIS_TET_QUARTER      2'h2
`define UIS_TET_HALF         2'h3
`define UIS_FIFO_DEPTH       5'h10
`define UIS_LVL_TWO          5'h02
`define UIS_LVL_QUARTER      5'h04
`define UIS_LVL_HALF         5'h08

// Receive trigger levels
`define UIS_RT_ONE           5'h01
`define UIS_RT_QUARTER       5'h04
`define UIS_RT_HALF          5'h08
`define UIS_RT_FULL2         5'h0E

// Character timeout: four character times in bit times
`define UIS_CTO_CHARS        4
`define UIS_BIT_CLKS         16

// Reset values
`define UIS_RST_IER          8'h00
`define UIS_RST_FCR          8'h00
`define UIS_RST_EVT_EN       5'h00

// Event bit positions in status, clear and enable registers
`define UIS_EVT_RLS          0
`define UIS_EVT_RDA          1
`define UIS_EVT_CTO          2
`define UIS_EVT_TX_HOLDING_EMPTY         3
`define UIS_EVT_ANY          4
`define UIS_EVT_W            5

`endif

// >>> bench/uis_irq_shadow_assertions.sv
/* Checker for uis_irq_shadow: APB answer, identification codes, aliases.
   Assumes it is bound to the design top and sees only its ports. */
`default_nettype none
module uis_irq_shadow_chk (
	input wire logic        mclk,           // Clock
	input wire logic        rst_n,          // Reset, active low
	input wire logic        psel,           // APB select
	input wire logic        penable,        // APB access
	input wire logic        pwrite,         // APB direction
	input wire logic [11:0] paddr,          // APB address
	input wire logic [31:0] pwdata,         // APB write data
	input wire logic [31:0] prdata,         // APB read data
	input wire logic        pready,         // APB ready
	input wire logic        pslverr,        // APB error
	input wire logic [7:0]  rx_data,        // Receive head
	input wire logic        rx_read_stb,    // Receive pop
	input wire logic        tx_write_stb,   // Holding push
	input wire logic [7:0]  tx_data,        // Holding data
	input wire logic [7:0]  fifo_control_q  // FIFO control
);
	timeunit 1ns;
	timeprecision 1ns;
	logic rd;
	logic wr;
	logic alias_hit;
	logic [7:0] fc;
	assign rd = psel && penable && pready && !pwrite;
	assign wr = psel && penable && pready && pwrite;
	assign alias_hit = paddr >= 12'h030 && paddr <= 12'h06C;
	assign fc = fifo_control_q;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
	a_ready_answer: assert property (psel && penable && !pready |=> pready)
		else $error("no answer");
	a_err_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
	a_id_code: assert property (rd && paddr == 12'h008 |->
		prdata[3:0] inside {4'h1, 4'h6, 4'h4, 4'hC, 4'h2}) else $error("bad id");
	a_alias_read: assert property (rd && alias_hit |->
		rx_read_stb && prdata[7:0] == $past(rx_data)) else $error("alias read");
	a_alias_write: assert property (wr && alias_hit |->
		tx_write_stb && tx_data == pwdata[7:0]) else $error("alias write");
	a_shadow_fe: assert property (wr && paddr == 12'h098 |=>
		fc == {$past(fc[7:1], 2), $past(pwdata[0])}) else $error("shadow enable");
	a_shadow_rt: assert property (wr && paddr == 12'h09C |=>
		fc == {$past(pwdata[1:0]), $past(fc[5:0], 2)}) else $error("shadow rx trigger");
	a_shadow_tet: assert property (wr && paddr == 12'h0A0 |=>
		fc == {$past(fc[7:6], 2), $past(pwdata[1:0]), $past(fc[3:0], 2)})
		else $error("shadow tx trigger");
	c_timeout: cover property (rd && paddr == 12'h008 && prdata[3:0] == 4'hC);
	c_error: cover property (pslverr);
	c_push: cover property (tx_write_stb);
endmodule
bind uis_irq_shadow uis_irq_shadow_chk u_chk (.mclk(mclk), .rst_n(rst_n), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .rx_data(rx_data), .rx_read_stb(rx_read_stb),
	.tx_write_stb(tx_write_stb), .tx_data(tx_data), .fifo_control_q(fifo_control_q));
`default_nettype wire

// >>> bench/uis_line_model.sv
/* Line-side model: FIFO fills, pops, free baud tick.
   Assumes the bench loads both fills with a one-cycle load pulse. */
`default_nettype none
module uis_line_model (
	input  wire logic       mclk,         // Clock
	input  wire logic       rst_n,        // Reset, active low
	input  wire logic       load,         // Take both fills
	input  wire logic [4:0] rx_set,       // Receive fill to load
	input  wire logic [4:0] tx_set,       // Transmit fill to load
	input  wire logic       rx_read_stb,  // Pop request
	input  wire logic       tx_write_stb, // Push request
	output var  logic [7:0] rx_data,      // Receive head
	output var  logic [4:0] rx_level,     // Receive fill
	output var  logic [4:0] tx_level,     // Transmit fill
	output var  logic       rx_pop,       // Character left
	output var  logic       baud_tick,    // One per cycle
	output var  logic       tx_idle,      // Idle when empty
	output var  logic [3:0] char_bits     // Ten bits a character
);
	timeunit 1ns;
	timeprecision 1ns;
	assign tx_idle = tx_level == 5'h00;
	assign char_bits = 4'hA;
	always_ff @(posedge mclk) begin
		baud_tick <= rst_n;
		rx_pop <= rst_n && rx_read_stb && rx_level != 5'h00;
		if (!rst_n) begin
			rx_level <= 5'h00;
			tx_level <= 5'h00;
			rx_data <= 8'h00;
		end else if (load) begin
			rx_level <= rx_set;
			tx_level <= tx_set;
		end else begin
			// New head each pop so stale data cannot pass
			if (rx_read_stb && rx_level != 5'h00) begin
				rx_level <= rx_level - 5'h01;
				rx_data <= 8'($urandom);
			end
			if (tx_write_stb && tx_level != 5'h10)
				tx_level <= tx_level + 5'h01;
		end
	end
endmodule
`default_nettype wire

// >>> bench/uis_irq_shadow_bench.sv
/* Self-checking bench for uis_irq_shadow driving APB and the line model.
   Assumes the checker binds itself from its own file. */
`default_nettype none
module uis_irq_shadow_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        mclk, rst_n, psel, penable, pwrite, load, rx_push;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [3:0]  err;
	logic [4:0]  rx_set, tx_set, v;
	logic [7:0]  f;
	wire  [31:0] prdata;
	wire  [7:0]  rx_data, tx_data, fifo_control_reg;
	wire  [4:0]  rx_level, tx_level;
	wire  [3:0]  char_bits;
	wire         pready, pslverr, rx_pop, tx_idle, baud_tick, rx_read_stb, tx_write_stb, irq;
	logic [32:0] exp_q[$];
	logic [31:0] msk_q[$];
	int          bad_count, checks_done, i;
	logic [4:0]  lvl [4] = '{5'h00, 5'h02, 5'h04, 5'h08};
	uis_irq_shadow u_dut (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rx_data(rx_data), .rx_level(rx_level), .tx_level(tx_level),
		.rx_push(rx_push), .rx_pop(rx_pop), .rx_overrun(err[0]), .rx_parity_err(err[1]),
		.rx_frame_err(err[2]), .rx_break(err[3]), .tx_idle(tx_idle), .baud_tick(baud_tick),
		.char_bits(char_bits), .rx_read_stb(rx_read_stb), .tx_write_stb(tx_write_stb),
		.tx_data(tx_data), .fifo_control_q(fifo_control_reg), .irq(irq));
	uis_line_model u_line (.mclk(mclk), .rst_n(rst_n), .load(load), .rx_set(rx_set),
		.tx_set(tx_set), .rx_read_stb(rx_read_stb), .tx_write_stb(tx_write_stb),
		.rx_data(rx_data), .rx_level(rx_level), .tx_level(tx_level), .rx_pop(rx_pop),
		.baud_tick(baud_tick), .tx_idle(tx_idle), .char_bits(char_bits));
	task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Idle edge after each transfer keeps psel from two writes in one step
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk) penable <= 1'h1;
		@(posedge mclk);
		while (pready !== 1'h1) @(posedge mclk);
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge mclk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		bus(1'h1, a, d);
	endtask
	task automatic rd(input logic [11:0] a, input logic [32:0] e, input logic [31:0] m);
		exp_q.push_back(e);
		msk_q.push_back(m);
		bus(1'h0, a, 32'h0);
	endtask
	task automatic setlv(input logic [4:0] r, input logic [4:0] t);
		rx_set <= r;
		tx_set <= t;
		load <= 1'h1;
		@(posedge mclk) load <= 1'h0;
		repeat (3) @(posedge mclk);
	endtask
	task automatic wirq(input logic e);
		int n = 0;
		while (irq !== e && n < 1000) begin
			@(posedge mclk);
			n++;
		end
		chk(irq, e);
	endtask
	always @(posedge mclk)
		if (pready && !pwrite)
			chk({pslverr, prdata & msk_q.pop_front()}, exp_q.pop_front());
	initial begin
		mclk = 1'h0;
		forever #5 mclk = ~mclk;
	end
	initial begin
		repeat (20000) @(posedge mclk);
		bad_count++;
		stop_test;
	end
	initial begin
		{rst_n, psel, penable, pwrite, load, rx_push, paddr, pwdata, err, rx_set, tx_set} = '0;
		f = 8'h00;
		void'($urandom(34));
		repeat (6) @(posedge mclk);
		rst_n <= 1'h1;
		@(posedge mclk);
		chk(fifo_control_reg, 8'h00);
		rd(12'h008, 33'h001, 32'hFF);
		rd(12'h200, 33'h100000000, 32'hFFFFFFFF);
		repeat (3) begin
			v = 5'($urandom);
			wr(12'h098, 32'(v[0]));
			f[0] = v[0];
			chk(fifo_control_reg, f);
			wr(12'h09C, 32'(v[2:1]));
			f[7:6] = v[2:1];
			chk(fifo_control_reg, f);
			wr(12'h0A0, 32'(v[4:3]));
			f[5:4] = v[4:3];
			chk(fifo_control_reg, f);
			rd(12'h09C, 33'(f[7:6]), 32'hFF);
		end
		wr(12'h098, 32'h1);
		setlv(5'h00, 5'h10);
		wr(12'h004, 32'h82);
		for (i = 0; i < 4; i++) begin
			setlv(5'h00, 5'h10);
			rd(12'h014, 33'h20, 32'h20);
			wr(12'h0A0, 32'(i));
			setlv(5'h00, lvl[i] + 5'h01);
			chk(irq, 1'h0);
			setlv(5'h00, lvl[i]);
			wirq(1'h1);
			if (i[0])
				setlv(5'h00, lvl[i] + 5'h01);
			else
				rd(12'h008, 33'h0C2, 32'hFF);
			wirq(1'h0);
			rd(12'h008, 33'h0C1, 32'hFF);
		end
		wr(12'h004, 32'h04);
		wr(12'h098, 32'h0);
		setlv(5'h00, 5'h00);
		rd(12'h014, 33'h20, 32'h20);
		setlv(5'h00, 5'h05);
		rd(12'h014, 33'h00, 32'h20);
		for (i = 0; i < 4; i++) begin
			err <= 4'(1 << i);
			@(posedge mclk) err <= 4'h0;
			wirq(1'h1);
			rd(12'h008, 33'h006, 32'hFF);
			rd(12'h014, 33'h010, 32'h10);
			rd(12'h008, 33'h001, 32'hFF);
			wirq(1'h0);
		end
		// Sticky status stays set while its enable masks the output
		rd(12'h0C0, 33'h001, 32'h01);
		wr(12'h0C8, 32'h01);
		wirq(1'h1);
		wr(12'h0C4, 32'h1F);
		wirq(1'h0);
		rd(12'h0C0, 33'h000, 32'h1F);
		wr(12'h0C8, 32'h00);
		wr(12'h098, 32'h1);
		wr(12'h09C, 32'h1);
		wr(12'h004, 32'h01);
		setlv(5'h03, 5'h10);
		chk(irq, 1'h0);
		setlv(5'h04, 5'h10);
		wirq(1'h1);
		rd(12'h008, 33'h0C4, 32'hFF);
		rd(12'h040, 33'(rx_data), 32'hFF);
		wirq(1'h0);
		repeat (400) @(posedge mclk);
		rx_push <= 1'h1;
		@(posedge mclk) rx_push <= 1'h0;
		repeat (400) @(posedge mclk);
		chk(irq, 1'h0);
		wirq(1'h1);
		rd(12'h008, 33'h0CC, 32'hFF);
		rd(12'h000, 33'(rx_data), 32'hFF);
		wirq(1'h0);
		f = 8'($urandom);
		wr(12'h050, 32'(f));
		wr(12'h000, 32'(~f));
		stop_test;
	end
endmodule
`default_nettype wire
